// ---- hw/flash_guard_pkg.sv ----
// Constants, register map and state types of the flash descriptor guard
package flash_guard_pkg;
	localparam int          LIN_W          = 27;
	localparam int          NUM_MASTERS    = 4;
	localparam int          NUM_REGIONS    = 6;
	localparam int          NUM_STEPS      = 17;
	// Descriptor layout
	localparam logic [11:0] DESC_LAST      = 12'h0_fff;
	localparam logic [11:0] OEM_BASE       = 12'h0_f00;
	localparam logic [11:0] SIG_OFS        = 12'h0_010;
	localparam logic [11:0] MAP0_OFS       = 12'h0_014;
	localparam logic [11:0] MAP1_OFS       = 12'h0_018;
	localparam logic [11:0] UPPER_MAP_OFS  = 12'h0_efc;
	localparam logic [11:0] COMP_DEF_OFS   = 12'h0_030;
	localparam logic [11:0] REGION_DEF_OFS = 12'h0_040;
	localparam logic [11:0] MASTER_DEF_OFS = 12'h0_080;
	localparam logic [11:0] STRAP_DEF_OFS  = 12'h0_100;
	localparam logic [11:0] UPPER_TBL_OFS  = 12'h0_c00;
	localparam logic [31:0] SIGNATURE      = 32'h0ff0_a55a;
	localparam logic [11:0] PAGE_MASK      = 12'h0_fff;
	// Step numbers of the descriptor walk
	localparam logic [4:0]  ST_SIG    = 5'h00;
	localparam logic [4:0]  ST_MAP0   = 5'h01;
	localparam logic [4:0]  ST_MAP1   = 5'h02;
	localparam logic [4:0]  ST_UPPER  = 5'h03;
	localparam logic [4:0]  ST_COMP0  = 5'h04;
	localparam logic [4:0]  ST_COMP1  = 5'h05;
	localparam logic [4:0]  ST_COMP2  = 5'h06;
	localparam logic [4:0]  ST_REG0   = 5'h07;
	localparam logic [4:0]  ST_MAST0  = 5'h0d;
	// Masters and their primary regions
	localparam logic [1:0]  M_HOST    = 2'h0;
	localparam logic [1:0]  M_ETH     = 2'h1;
	localparam logic [1:0]  M_MGMT    = 2'h2;
	localparam logic [1:0]  M_EC      = 2'h3;
	localparam logic [2:0]  R_HOST    = 3'h1;
	localparam logic [2:0]  R_MGMT    = 3'h2;
	localparam logic [2:0]  R_ETH     = 3'h3;
	localparam logic [2:0]  R_EC      = 3'h5;
	// Register byte offsets
	localparam logic [7:0]  A_CTRL    = 8'h00;
	localparam logic [7:0]  A_STATUS  = 8'h04;
	localparam logic [7:0]  A_ERR     = 8'h08;
	localparam logic [7:0]  A_ERR_LIN = 8'h0c;
	localparam logic [7:0]  A_COMP    = 8'h10;
	localparam logic [7:0]  A_BLK_OP  = 8'h14;
	localparam logic [7:0]  A_FREQ    = 8'h18;
	localparam logic [7:0]  A_VTABLE  = 8'h1c;
	localparam logic [1:0]  RESP_OK   = 2'h0;
	localparam logic [1:0]  RESP_DEC  = 2'h3;
	typedef enum logic [2:0] {L_REQ, L_WAIT, L_DONE, L_FAIL} load_state_t;
	typedef enum logic [1:0] {D_IDLE, D_FETCH, D_WAIT, D_RESP} dread_state_t;
endpackage

// ---- hw/flash_descriptor_access_guard.sv ----
// Descriptor loader, direct read guard and program access guard for shared flash
`timescale 1ns/100ps
module flash_descriptor_access_guard #(
	parameter int LIN_W = flash_guard_pkg::LIN_W
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [7:0]       s_axi_awaddr,
	input  wire logic             s_axi_awvalid,
	output logic                  s_axi_awready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	input  wire logic             s_axi_wvalid,
	output logic                  s_axi_wready,
	output logic [1:0]            s_axi_bresp,
	output logic                  s_axi_bvalid,
	input  wire logic             s_axi_bready,
	input  wire logic [7:0]       s_axi_araddr,
	input  wire logic             s_axi_arvalid,
	output logic                  s_axi_arready,
	output logic [31:0]           s_axi_rdata,
	output logic [1:0]            s_axi_rresp,
	output logic                  s_axi_rvalid,
	input  wire logic             s_axi_rready,
	output logic                  flash_rd_valid,
	input  wire logic             flash_rd_ready,
	output logic [LIN_W-1:0]      flash_rd_addr,
	input  wire logic             flash_rd_done,
	input  wire logic [31:0]      flash_rd_data,
	input  wire logic             dr_valid,
	output logic                  dr_ready,
	input  wire logic [1:0]       dr_master,
	input  wire logic [7:0]       dr_rid,
	input  wire logic             dr_write,
	input  wire logic [LIN_W-1:0] dr_addr,
	output logic                  dr_resp_valid,
	input  wire logic             dr_resp_ready,
	output logic                  dr_resp_err,
	output logic [31:0]           dr_resp_data,
	input  wire logic             pr_valid,
	output logic                  pr_ready,
	input  wire logic [1:0]       pr_master,
	input  wire logic             pr_write,
	input  wire logic [LIN_W-1:0] pr_lin,
	input  wire logic [6:0]       pr_len,
	input  wire logic [7:0]       pr_opcode,
	output logic                  pr_grant,
	output logic                  pr_deny
);
	localparam int NR = flash_guard_pkg::NUM_REGIONS;
	localparam int NM = flash_guard_pkg::NUM_MASTERS;

	flash_guard_pkg::load_state_t  ld_state_ff;
	flash_guard_pkg::dread_state_t dr_state_ff;
	logic [4:0]       step_ff;
	logic [31:0]      map0_ff, map1_ff, upper_ff, comp0_ff, comp1_ff, comp2_ff;
	logic [31:0]      region_ff [NR];
	logic [31:0]      master_ff [NM];
	logic             sig_bad_ff, ptr_bad_ff, reload_ff;
	logic [1:0]       err_ff;
	logic [LIN_W-1:0] err_lin_ff;
	logic [11:0]      step_ofs;
	logic             loaded;

	// Map pointer fields are 16-byte units inside the descriptor
	function automatic logic [11:0] ptr(input logic [7:0] f);
		ptr = {f, 4'h0};
	endfunction

	function automatic logic [2:0] primary_of(input logic [1:0] m);
		unique case (m)
			flash_guard_pkg::M_HOST: primary_of = flash_guard_pkg::R_HOST;
			flash_guard_pkg::M_ETH:  primary_of = flash_guard_pkg::R_ETH;
			flash_guard_pkg::M_MGMT: primary_of = flash_guard_pkg::R_MGMT;
			flash_guard_pkg::M_EC:   primary_of = flash_guard_pkg::R_EC;
		endcase
	endfunction

	function automatic logic [LIN_W-1:0] rbase(input logic [31:0] w);
		rbase = {w[14:0], 12'h000};
	endfunction

	function automatic logic [LIN_W-1:0] rlimit(input logic [31:0] w);
		rlimit = {w[30:16], 12'hfff};
	endfunction

	assign loaded = (ld_state_ff == flash_guard_pkg::L_DONE);

	// Offset of each walk step, kept 12 bits wide so nothing past 4 KB is reached
	always_comb
	begin
		step_ofs = flash_guard_pkg::SIG_OFS;
		if (step_ff == flash_guard_pkg::ST_MAP0)
			step_ofs = flash_guard_pkg::MAP0_OFS;
		else if (step_ff == flash_guard_pkg::ST_MAP1)
			step_ofs = flash_guard_pkg::MAP1_OFS;
		else if (step_ff == flash_guard_pkg::ST_UPPER)
			step_ofs = flash_guard_pkg::UPPER_MAP_OFS;
		else if (step_ff >= flash_guard_pkg::ST_MAST0)
			step_ofs = ptr(map1_ff[7:0]) + {5'h00, step_ff - flash_guard_pkg::ST_MAST0, 2'h0};
		else if (step_ff >= flash_guard_pkg::ST_REG0)
			step_ofs = ptr(map0_ff[23:16]) + {5'h00, step_ff - flash_guard_pkg::ST_REG0, 2'h0};
		else if (step_ff >= flash_guard_pkg::ST_COMP0)
			step_ofs = ptr(map0_ff[7:0]) + {5'h00, step_ff - flash_guard_pkg::ST_COMP0, 2'h0};
	end

	// Descriptor walk
	always_ff @(posedge aclk)
	begin
		if (!aresetn || reload_ff)
		begin
			ld_state_ff <= flash_guard_pkg::L_REQ;
			step_ff     <= 5'h00;
			sig_bad_ff  <= 1'b0;
			ptr_bad_ff  <= 1'b0;
		end
		else
		begin
			unique case (ld_state_ff)
				flash_guard_pkg::L_REQ:
					if (step_ofs >= flash_guard_pkg::OEM_BASE)
					begin
						ptr_bad_ff  <= 1'b1;
						ld_state_ff <= flash_guard_pkg::L_FAIL;
					end
					else if (flash_rd_ready)
						ld_state_ff <= flash_guard_pkg::L_WAIT;
				flash_guard_pkg::L_WAIT:
					if (flash_rd_done)
					begin
						if (step_ff == flash_guard_pkg::ST_SIG
						    && flash_rd_data != flash_guard_pkg::SIGNATURE)
						begin
							sig_bad_ff  <= 1'b1;
							ld_state_ff <= flash_guard_pkg::L_FAIL;
						end
						else if (step_ff == 5'(flash_guard_pkg::NUM_STEPS - 1))
							ld_state_ff <= flash_guard_pkg::L_DONE;
						else
						begin
							step_ff     <= step_ff + 5'h01;
							ld_state_ff <= flash_guard_pkg::L_REQ;
						end
					end
				flash_guard_pkg::L_DONE: ld_state_ff <= flash_guard_pkg::L_DONE;
				flash_guard_pkg::L_FAIL: ld_state_ff <= flash_guard_pkg::L_FAIL;
				default:                 ld_state_ff <= flash_guard_pkg::L_FAIL;
			endcase
		end
	end

	// Capture of descriptor words
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			map0_ff  <= 32'h0000_0000;
			map1_ff  <= 32'h0000_0000;
			upper_ff <= 32'h0000_0000;
			comp0_ff <= 32'h0000_0000;
			comp1_ff <= 32'h0000_0000;
			comp2_ff <= 32'h0000_0000;
			for (int i = 0; i < NR; i++)
				region_ff[i] <= 32'h0000_0000;
			for (int i = 0; i < NM; i++)
				master_ff[i] <= 32'h0000_0000;
		end
		else if (ld_state_ff == flash_guard_pkg::L_WAIT && flash_rd_done)
		begin
			if (step_ff == flash_guard_pkg::ST_MAP0)
				map0_ff <= flash_rd_data;
			if (step_ff == flash_guard_pkg::ST_MAP1)
				map1_ff <= flash_rd_data;
			if (step_ff == flash_guard_pkg::ST_UPPER)
				upper_ff <= flash_rd_data;
			if (step_ff == flash_guard_pkg::ST_COMP0)
				comp0_ff <= flash_rd_data;
			if (step_ff == flash_guard_pkg::ST_COMP1)
				comp1_ff <= flash_rd_data;
			if (step_ff == flash_guard_pkg::ST_COMP2)
				comp2_ff <= flash_rd_data;
			for (int i = 0; i < NR; i++)
				if (step_ff == flash_guard_pkg::ST_REG0 + 5'(i))
					region_ff[i] <= flash_rd_data;
			for (int i = 0; i < NM; i++)
				if (step_ff == flash_guard_pkg::ST_MAST0 + 5'(i))
					master_ff[i] <= flash_rd_data;
		end
	end

	// Direct read checks on the offered request
	logic [2:0]       dr_region;
	logic [LIN_W-1:0] dr_lin, dr_base, dr_lim;
	logic             dr_ok, dr_hit;
	logic [1:0]       cache_owner_ff;
	logic [LIN_W-1:0] cache_addr_ff;
	logic [31:0]      cache_data_ff;
	logic             cache_full_ff;
	logic [LIN_W-1:0] fetch_addr_ff;

	assign dr_region = primary_of(dr_master);
	assign dr_base   = rbase(region_ff[dr_region]);
	assign dr_lim    = rlimit(region_ff[dr_region]);
	assign dr_lin    = (dr_master == flash_guard_pkg::M_HOST
	                   || dr_master == flash_guard_pkg::M_MGMT)
	                   ? LIN_W'(dr_base + dr_addr) : dr_addr;
	assign dr_ok     = !dr_write
	                   && dr_rid == master_ff[dr_master][7:0]
	                   && dr_lin >= dr_base && dr_lin <= dr_lim
	                   && master_ff[dr_master][8 + dr_region];
	assign dr_hit    = cache_full_ff && cache_owner_ff == dr_master
	                   && cache_addr_ff == {dr_lin[LIN_W-1:2], 2'h0};
	assign dr_ready  = loaded && dr_state_ff == flash_guard_pkg::D_IDLE;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			dr_state_ff   <= flash_guard_pkg::D_IDLE;
			dr_resp_valid <= 1'b0;
			dr_resp_err   <= 1'b0;
			dr_resp_data  <= 32'h0000_0000;
			fetch_addr_ff <= '0;
		end
		else
		begin
			unique case (dr_state_ff)
				flash_guard_pkg::D_IDLE:
					if (dr_valid && dr_ready)
					begin
						fetch_addr_ff <= {dr_lin[LIN_W-1:2], 2'h0};
						if (!dr_ok || dr_hit)
						begin
							dr_resp_valid <= 1'b1;
							dr_resp_err   <= !dr_ok;
							dr_resp_data  <= dr_ok ? cache_data_ff : 32'h0000_0000;
							dr_state_ff   <= flash_guard_pkg::D_RESP;
						end
						else
							dr_state_ff <= flash_guard_pkg::D_FETCH;
					end
				flash_guard_pkg::D_FETCH:
					if (flash_rd_ready)
						dr_state_ff <= flash_guard_pkg::D_WAIT;
				flash_guard_pkg::D_WAIT:
					if (flash_rd_done)
					begin
						dr_resp_valid <= 1'b1;
						dr_resp_err   <= 1'b0;
						dr_resp_data  <= flash_rd_data;
						dr_state_ff   <= flash_guard_pkg::D_RESP;
					end
				flash_guard_pkg::D_RESP:
					if (dr_resp_ready)
					begin
						dr_resp_valid <= 1'b0;
						dr_state_ff   <= flash_guard_pkg::D_IDLE;
					end
			endcase
		end
	end

	// Direct read cache
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cache_owner_ff <= flash_guard_pkg::M_HOST;
			cache_addr_ff  <= '0;
			cache_data_ff  <= 32'h0000_0000;
			cache_full_ff  <= 1'b0;
		end
		else if (dr_valid && dr_ready && dr_master != cache_owner_ff)
		begin
			cache_owner_ff <= dr_master;
			cache_data_ff  <= 32'h0000_0000;
			cache_full_ff  <= 1'b0;
		end
		else if (dr_state_ff == flash_guard_pkg::D_WAIT && flash_rd_done)
		begin
			cache_addr_ff <= fetch_addr_ff;
			cache_data_ff <= flash_rd_data;
			cache_full_ff <= 1'b1;
		end
	end

	// Flash read port, loader before descriptor mode and direct reads after
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			flash_rd_valid <= 1'b0;
			flash_rd_addr  <= '0;
		end
		else if (flash_rd_valid && flash_rd_ready)
			flash_rd_valid <= 1'b0;
		else if (!flash_rd_valid && ld_state_ff == flash_guard_pkg::L_REQ && !reload_ff
		         && step_ofs < flash_guard_pkg::OEM_BASE)
		begin
			flash_rd_valid <= 1'b1;
			flash_rd_addr  <= LIN_W'(step_ofs);
		end
		else if (!flash_rd_valid && dr_state_ff == flash_guard_pkg::D_FETCH)
		begin
			flash_rd_valid <= 1'b1;
			flash_rd_addr  <= fetch_addr_ff;
		end
	end

	// Program register access checks
	logic [2:0]       pr_region;
	logic [LIN_W-1:0] pr_end, pr_base, pr_lim, comp0_size;
	logic             pr_ok, pr_blocked, pr_cross_comp;

	assign pr_ready   = loaded;
	assign pr_region  = primary_of(pr_master);
	assign pr_base    = rbase(region_ff[pr_region]);
	assign pr_lim     = rlimit(region_ff[pr_region]);
	assign pr_end     = LIN_W'(pr_lin + LIN_W'(pr_len) - LIN_W'(1));
	assign comp0_size = LIN_W'({{(LIN_W-1){1'b0}}, 1'b1} << (19 + comp0_ff[3:0]));
	assign pr_blocked = pr_opcode == comp1_ff[7:0] || pr_opcode == comp1_ff[15:8]
	                    || pr_opcode == comp1_ff[23:16] || pr_opcode == comp1_ff[31:24];
	assign pr_cross_comp = map0_ff[9:8] != 2'h0 && pr_lin < comp0_size && pr_end >= comp0_size;
	assign pr_ok      = pr_len != 7'h00
	                    && pr_end[LIN_W-1:12] == pr_lin[LIN_W-1:12]
	                    && !pr_cross_comp
	                    && pr_lin >= pr_base && pr_end <= pr_lim
	                    && !pr_blocked
	                    && master_ff[pr_master][(pr_write ? 16 : 8) + pr_region];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pr_grant <= 1'b0;
			pr_deny  <= 1'b0;
		end
		else
		begin
			pr_grant <= pr_valid && pr_ready && pr_ok;
			pr_deny  <= pr_valid && pr_ready && !pr_ok;
		end
	end

	// AXI4-Lite slave
	logic       aw_held_ff, w_held_ff;
	logic [7:0] aw_addr_ff;
	logic [31:0] w_data_ff;
	logic       wr_fire, err_clr_hit;
	logic [31:0] rd_word;
	logic [1:0]  rd_resp;

	assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_ff && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_fire       = aw_held_ff && w_held_ff && !s_axi_bvalid;
	assign err_clr_hit   = wr_fire && aw_addr_ff == flash_guard_pkg::A_ERR;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_ff   <= 1'b0;
			w_held_ff    <= 1'b0;
			aw_addr_ff   <= 8'h00;
			w_data_ff    <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= flash_guard_pkg::RESP_OK;
			reload_ff    <= 1'b0;
		end
		else
		begin
			reload_ff <= 1'b0;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_ff <= 1'b1;
				w_data_ff <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
				                            {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
			end
			if (wr_fire)
			begin
				aw_held_ff   <= 1'b0;
				w_held_ff    <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= aw_addr_ff > flash_guard_pkg::A_VTABLE || aw_addr_ff[1:0] != 2'h0
				                ? flash_guard_pkg::RESP_DEC : flash_guard_pkg::RESP_OK;
				reload_ff    <= aw_addr_ff == flash_guard_pkg::A_CTRL && w_data_ff[0];
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Sticky check-failure flags; a new failure wins over a clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			err_ff     <= 2'h0;
			err_lin_ff <= '0;
		end
		else
		begin
			err_ff[0] <= (err_ff[0] && !(err_clr_hit && w_data_ff[0]))
			             || (dr_valid && dr_ready && !dr_ok);
			err_ff[1] <= (err_ff[1] && !(err_clr_hit && w_data_ff[1]))
			             || (pr_valid && pr_ready && !pr_ok);
			if (dr_valid && dr_ready && !dr_ok)
				err_lin_ff <= dr_lin;
			else if (pr_valid && pr_ready && !pr_ok)
				err_lin_ff <= pr_lin;
		end
	end

	always_comb
	begin
		rd_resp = flash_guard_pkg::RESP_OK;
		unique case (s_axi_araddr)
			flash_guard_pkg::A_CTRL:    rd_word = 32'h0000_0000;
			flash_guard_pkg::A_STATUS:  rd_word = {28'h000_0000, !loaded && ld_state_ff !=
			                              flash_guard_pkg::L_FAIL, ptr_bad_ff, sig_bad_ff, loaded};
			flash_guard_pkg::A_ERR:     rd_word = {30'h0000_0000, err_ff};
			flash_guard_pkg::A_ERR_LIN: rd_word = 32'(err_lin_ff);
			flash_guard_pkg::A_COMP:    rd_word = {22'h00_0000, map0_ff[9:8], comp0_ff[7:0]};
			flash_guard_pkg::A_BLK_OP:  rd_word = comp1_ff;
			flash_guard_pkg::A_FREQ:    rd_word = comp2_ff;
			flash_guard_pkg::A_VTABLE:  rd_word = {16'h0000, upper_ff[15:0]};
			default:
			begin
				rd_word = 32'h0000_0000;
				rd_resp = flash_guard_pkg::RESP_DEC;
			end
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= flash_guard_pkg::RESP_OK;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_resp;
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// Checks
	sequence dr_take_s;
		dr_valid && dr_ready;
	endsequence

	sequence denied_resp_s;
		dr_resp_valid && dr_resp_err && dr_resp_data == 32'h0000_0000;
	endsequence

	chk_sig_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		loaded |-> !sig_bad_ff && !ptr_bad_ff)
		else $error("descriptor mode entered without a valid walk");
	chk_direct_write: assert property (@(posedge aclk) disable iff (!aresetn)
		(dr_take_s and dr_write) |=> denied_resp_s)
		else $error("direct write not refused");
	chk_rid_match: assert property (@(posedge aclk) disable iff (!aresetn)
		(dr_take_s and (dr_rid != master_ff[dr_master][7:0])) |=> denied_resp_s ##1 err_ff[0])
		else $error("requester id mismatch not rejected");
	chk_range_deny: assert property (@(posedge aclk) disable iff (!aresetn)
		(dr_take_s and (dr_lin > dr_lim || dr_lin < dr_base)) |=> dr_resp_err)
		else $error("out of range direct read not rejected");
	chk_cache_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		(dr_take_s and (dr_master != cache_owner_ff)) |=> cache_data_ff == 32'h0000_0000
		&& !cache_full_ff)
		else $error("cache not cleared on master change");
	chk_pr_page: assert property (@(posedge aclk) disable iff (!aresetn)
		pr_grant |-> $past(pr_end[LIN_W-1:12]) == $past(pr_lin[LIN_W-1:12]))
		else $error("program access crossed a 4 KB page");
	chk_pr_owner: assert property (@(posedge aclk) disable iff (!aresetn)
		pr_grant |-> $past(pr_lin) >= $past(pr_base) && $past(pr_end) <= $past(pr_lim))
		else $error("program access granted outside owned region");
	chk_oem_skip: assert property (@(posedge aclk) disable iff (!aresetn)
		flash_rd_valid && !loaded |-> flash_rd_addr < LIN_W'(flash_guard_pkg::OEM_BASE))
		else $error("descriptor walk touched the top 256 bytes");
	chk_err_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		err_ff[1] && !err_clr_hit |=> err_ff[1])
		else $error("sticky failure flag lost");
	chk_resp_stay: assert property (@(posedge aclk) disable iff (!aresetn)
		dr_resp_valid && !dr_resp_ready |=> dr_resp_valid && $stable(dr_resp_data))
		else $error("direct response dropped before taken");
endmodule

// ---- tb/flash_model.sv ----
// Flash model serving descriptor and region words
`timescale 1ns/100ps
module flash_model (
	input  wire logic        aclk,
	input  wire logic        bad_sig,
	input  wire logic        rd_valid,
	output logic             rd_ready,
	input  wire logic [26:0] rd_addr,
	output logic             rd_done,
	output logic [31:0]      rd_data
);
	logic [26:0] a_ff;
	logic [1:0]  n_ff;
	function automatic logic [31:0] word(input logic [26:0] a);
		case (a)
			27'h10: return bad_sig ? 32'h0000_0000 : 32'h0ff0_a55a;
			27'h14: return 32'h0004_0003;
			27'h18: return 32'h0000_0008;
			27'hefc: return 32'h0000_2040;
			27'h30: return 32'h0000_0003;
			27'h34: return 32'h6060_c7c7;
			27'h38: return 32'h0000_0123;
			default: ;
		endcase
		if (a >= 27'h40 && a < 27'h58)
			return {2{13'h0000, a[4:2]}};
		if (a >= 27'h80 && a < 27'h90)
			return 32'h003e_3f10 | {30'h0000_0000, a[3:2]};
		return {5'h00, a} ^ 32'h5a5a_0000;
	endfunction
	initial
	begin
		rd_ready = 1'b0;
		rd_done = 1'b0;
		n_ff = 2'h0;
	end
	// Late ready, then done after a wait; data inverted outside done
	always @(posedge aclk)
	begin
		rd_done <= n_ff == 2'h1;
		if (rd_valid && !rd_ready && n_ff == 2'h0)
		begin
			rd_ready <= 1'b1;
			a_ff <= rd_addr;
		end
		else if (rd_ready)
		begin
			rd_ready <= 1'b0;
			n_ff <= 2'h3;
		end
		else if (n_ff != 2'h0)
			n_ff <= n_ff - 2'h1;
	end
	assign rd_data = rd_done ? word(a_ff) : ~word(a_ff);
endmodule

// ---- tb/flash_descriptor_access_guard_tb.sv ----
// Register, direct read and program access tests of the guard
`timescale 1ns/100ps
module flash_descriptor_access_guard_tb;
	logic aclk, aresetn, awv, wv, bv, brd, arv, ard, rv, frv, frr, fdn, dv, dry, dw;
	logic drv, drr, de, pv, pry, pw, pg, pd, bs;
	logic aw_r, w_r;
	logic [7:0]  awa, ara, rid;
	logic [31:0] wd, rdt, fd, dd, d;
	logic [1:0]  br, rr, dm, pm, r;
	logic [26:0] fa, da, pf;
	logic [6:0]  pl;
	logic [7:0]  po;
	int bad_count, checks;
	flash_descriptor_access_guard uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(aw_r), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wv), .s_axi_wready(w_r), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(ard),
		.s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
		.flash_rd_valid(frv), .flash_rd_ready(frr), .flash_rd_addr(fa), .flash_rd_done(fdn),
		.flash_rd_data(fd), .dr_valid(dv), .dr_ready(dry), .dr_master(dm), .dr_rid(rid),
		.dr_write(dw), .dr_addr(da), .dr_resp_valid(drv), .dr_resp_ready(drr),
		.dr_resp_err(de), .dr_resp_data(dd), .pr_valid(pv), .pr_ready(pry), .pr_master(pm),
		.pr_write(pw), .pr_lin(pf), .pr_len(pl), .pr_opcode(po), .pr_grant(pg), .pr_deny(pd));
	flash_model fm (.aclk(aclk), .bad_sig(bs), .rd_valid(frv), .rd_ready(frr), .rd_addr(fa),
		.rd_done(fdn), .rd_data(fd));
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] v);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		{awa, wd, awv, wv, brd} <= {a, v, 3'h7};
		do
		begin
			@(posedge aclk);
			ta = ta | aw_r;
			tw = tw | w_r;
			awv <= !ta;
			wv <= !tw;
		end
		while (!(ta && tw));
		do @(posedge aclk); while (!bv);
		brd <= 1'b0;
		chk("bresp", 32'h0000_0000, {30'h0, br});
	endtask
	task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		{ara, arv} <= {a, 1'b1};
		do @(posedge aclk); while (!ard);
		arv <= 1'b0;
		do @(posedge aclk); while (!rv);
		chk("rdata", e, rdt);
		chk("rresp", {30'h0, er}, {30'h0, rr});
	endtask
	task automatic pol(input logic [31:0] m);
		repeat (60)
		begin
			{ara, arv} <= {8'h04, 1'b1};
			do @(posedge aclk); while (!ard);
			arv <= 1'b0;
			do @(posedge aclk); while (!rv);
			if ((rdt & m) != 0)
				return;
		end
	endtask
	task automatic drd(input logic [1:0] m, input logic [7:0] i, input logic w,
		input logic [26:0] a, input logic e, input logic [26:0] f);
		{dm, rid, dw, da, dv, drr} <= {m, i, w, a, 2'h2};
		do @(posedge aclk); while (!dry);
		dv <= 1'b0;
		do @(posedge aclk); while (!drv);
		drr <= 1'b1;
		@(posedge aclk);
		chk("dr_hold", 32'h0000_0001, {31'h0, drv});
		chk("dr_err", {31'h0, e}, {31'h0, de});
		chk("dr_data", e ? 32'h0000_0000 : fm.word(f), dd);
	endtask
	task automatic prg(input logic [1:0] m, input logic [26:0] f, input logic [6:0] n,
		input logic [7:0] o, input logic g);
		{pm, pw, pf, pl, po, pv} <= {m, 1'b0, f, n, o, 1'b1};
		do @(posedge aclk); while (!pry);
		pv <= 1'b0;
		@(posedge aclk);
		chk("grant", {31'h0, g}, {31'h0, pg});
		chk("deny", {31'h0, !g}, {31'h0, pd});
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	initial
	begin
		#400000;
		bad_count++;
		stop_test();
	end
	initial
	begin
		{aresetn, awv, wv, brd, arv, dv, drr, pv, bs, bad_count, checks} = 0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		pol(32'h0000_0007);
		axr(8'h04, 32'h0000_0001, 2'h0);
		axr(8'h10, 32'h0000_0003, 2'h0);
		axr(8'h14, 32'h6060_c7c7, 2'h0);
		axr(8'h18, 32'h0000_0123, 2'h0);
		axr(8'h1c, 32'h0000_2040, 2'h0);
		axr(8'h40, 32'h0000_0000, 2'h3);
		$display("test registers done");
		drd(2'h0, 8'h10, 1'b0, 27'h10, 1'b0, 27'h1010);
		drd(2'h0, 8'h11, 1'b0, 27'h10, 1'b1, 27'h0);
		drd(2'h0, 8'h10, 1'b1, 27'h10, 1'b1, 27'h0);
		drd(2'h2, 8'h12, 1'b0, 27'h8, 1'b0, 27'h2008);
		drd(2'h3, 8'h13, 1'b0, 27'h5ffc, 1'b0, 27'h5ffc);
		drd(2'h1, 8'h11, 1'b0, 27'h3004, 1'b0, 27'h3004);
		drd(2'h0, 8'h10, 1'b0, 27'h10, 1'b0, 27'h1010);
		drd(2'h1, 8'h11, 1'b0, 27'h1004, 1'b1, 27'h0);
		axr(8'h08, 32'h0000_0001, 2'h0);
		axr(8'h0c, 32'h0000_1004, 2'h0);
		axw(8'h08, 32'h0000_0001);
		axr(8'h08, 32'h0000_0000, 2'h0);
		$display("test direct done");
		prg(2'h0, 27'h1000, 7'h04, 8'h03, 1'b1);
		prg(2'h0, 27'h1ffe, 7'h04, 8'h03, 1'b0);
		prg(2'h1, 27'h1000, 7'h04, 8'h03, 1'b0);
		prg(2'h0, 27'h1000, 7'h04, 8'hc7, 1'b0);
		prg(2'h3, 27'h5000, 7'h40, 8'h02, 1'b1);
		axr(8'h08, 32'h0000_0002, 2'h0);
		axr(8'h0c, 32'h0000_1000, 2'h0);
		$display("test program done");
		bs <= 1'b1;
		axw(8'h00, 32'h0000_0001);
		pol(32'h0000_0002);
		axr(8'h04, 32'h0000_0002, 2'h0);
		$display("test signature done");
		stop_test();
	end
endmodule
